/* test/gpol_btn_model.sv */
// Purpose: buttons, key matrix and LED seen at the pads
// Assumes: matrix keys join pin 4 to one of pins 3..1
// Notes: a floating pin toggles each cycle, never holds a value
`timescale 1ns/1ns
module gpol_btn_model #(
	parameter int PINS = 8
) (
	// clock
	input  wire logic            core_clk,
	// pads
	input  wire logic [PINS-1:0] pin_out,
	input  wire logic [PINS-1:0] pin_oe,
	input  wire logic [PINS-1:0] pin_pullup_en,
	input  wire logic [PINS-1:0] pin_pulldown_en,
	output logic      [PINS-1:0] pin_in,
	// buttons
	input  wire logic [PINS-1:0] press,
	input  wire logic [2:0]      mx_key
);
	logic tog = 1'b0;
	always @(posedge core_clk) tog <= ~tog;
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (press[i])
				pin_in[i] = 1'b0;
			// led to supply lifts pin 5 when undriven
			else if (pin_pullup_en[i] || i == 5)
				pin_in[i] = 1'b1;
			else if (pin_pulldown_en[i])
				pin_in[i] = 1'b0;
			else
				pin_in[i] = tog ^ i[0];
		end
		for (int r = 0; r < 3; r++)
			if (mx_key[r] && !pin_in[r+1] && !pin_oe[4])
				pin_in[4] = 1'b0;
	end
endmodule

/* test/tb_top.sv */
// Purpose: self-checking bench for the pad option block
// Assumes: eight pins, bench masters the register port
// Notes: read data checked mid-cycle by a queue-fed monitor
`timescale 1ns/1ns
`include "gpol_cfg.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
	import gpol_pkg::*;
	logic       core_clk = 1'b0, rst = 1'b1, pad_rst = 1'b1;
	logic       reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
	gpol_addr_t reg_addr = '0;
	gpol_byte_t reg_wdata = '0;
	logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, pin_pullup_en, pin_pulldown_en;
	logic [7:0] press = '0, v, e, m;
	logic [2:0] mx_key = '0;
	logic       shutdown = 1'b0, nvm_prog = 1'b0, debug_active = 1'b0, cust_clk = 1'b0;
	logic       debug_data_out = 1'b0, debug_data_oe = 1'b0;
	logic       debug_data_pin, debug_clock_pin, freq_ref_clk, crystal_osc_input;
	logic       xtal_enable, led_drive_en, wake_req, opt_matrix, opt_roff;
	logic [7:0] exp_q[$], msk_q[$];
	logic [2:0] pats[4] = '{3'b110, 3'b101, 3'b011, 3'b111};
	int         failures = 0, samples_checked = 0, cyc = 0, seed = 2;
	gpol_pad_option #(.PINS(8)) uut (.core_clk, .rst, .pad_rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe, .pin_pullup_en,
		.pin_pulldown_en, .shutdown, .nvm_prog, .debug_active, .debug_data_out,
		.debug_data_oe, .cust_clk, .debug_data_pin, .debug_clock_pin, .freq_ref_clk,
		.crystal_osc_input, .xtal_enable, .led_drive_en, .wake_req, .opt_matrix, .opt_roff);
	gpol_btn_model #(.PINS(8)) pads (.core_clk, .pin_out, .pin_oe, .pin_pullup_en,
		.pin_pulldown_en, .pin_in, .press, .mx_key);
	always #4 core_clk = ~core_clk;
	task automatic summarize;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			summarize();
		end
	end
	// mid-cycle sampling keeps clear of the edge that updates read data
	always @(negedge core_clk) begin
		if (rd_seen) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			`CHK("reg_rdata", e, reg_rdata & m)
		end
		rd_seen = reg_rd;
	end
	task automatic w(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(gpol_addr_t a, logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		w(1);
	endtask
	task automatic rd(gpol_addr_t a, logic [7:0] x, logic [7:0] k);
		exp_q.push_back(x);
		msk_q.push_back(k);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		w(1);
	endtask
	task automatic latch(logic [7:0] d);
		wr(`GPOL_OFS_CTRL, d);
		wr(`GPOL_OFS_CTRL, d | 8'h80);
		wr(`GPOL_OFS_CTRL, d);
		w(2);
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		pad_rst <= 1'b0;
		w(1);
		rd(`GPOL_OFS_OUT, 8'hFF, 8'hFF);
		rd(`GPOL_OFS_DRV, 8'h00, 8'hFF);
		rd(`GPOL_OFS_CTRL, 8'h00, 8'hE0);
		rd(5'h18, 8'h00, 8'hFF);
		v = 8'($random(seed));
		wr(`GPOL_OFS_OUT, v);
		rd(`GPOL_OFS_OUT, v, 8'hFF);
		wr(`GPOL_OFS_OUT, 8'hFF);
		wr(`GPOL_OFS_CTRL, 8'h40);
		rd(`GPOL_OFS_CTRL, 8'h00, 8'hE0);
		latch(8'h40);
		`CHK("opt_matrix", 1'b1, opt_matrix)
		`CHK("pulldown", 3'b111, pin_pulldown_en[3:1])
		`CHK("pullup", 3'b000, pin_pullup_en[3:1])
		rd(`GPOL_OFS_CTRL, 8'h40, 8'hE0);
		shutdown <= 1'b1;
		mx_key <= 3'b010;
		w(1);
		`CHK("drv_oe", 3'b111, pin_oe[3:1])
		`CHK("drv_out", 3'b000, pin_out[3:1])
		`CHK("wake", 1'b1, wake_req)
		rst <= 1'b1;
		w(2);
		rst <= 1'b0;
		w(2);
		`CHK("kept", 1'b1, opt_matrix)
		shutdown <= 1'b0;
		latch(8'h00);
		foreach (pats[k]) begin
			wr(`GPOL_OFS_OUT, {4'hF, pats[k], 1'b1});
			w(3);
			rd(`GPOL_OFS_PIN, {3'b000, pats[k][1], 4'h0}, 8'h10);
		end
		mx_key <= '0;
		latch(8'h20);
		`CHK("roff_pu", 2'b00, pin_pullup_en[2:1])
		`CHK("opt_roff", 1'b1, opt_roff)
		latch(8'h00);
		wr(`GPOL_OFS_OUT, 8'hF7);
		wr(`GPOL_OFS_SET, 8'h01);
		press[3] <= 1'b1;
		w(3);
		`CHK("ref_oe", 1'b0, pin_oe[3])
		`CHK("ref_lo", 1'b0, freq_ref_clk)
		press[3] <= 1'b0;
		w(2);
		`CHK("ref_hi", 1'b1, freq_ref_clk)
		wr(`GPOL_OFS_OUT, 8'hFE);
		cust_clk <= 1'b1;
		for (int s = 1; s < 4; s++) begin
			wr(`GPOL_OFS_SET, 8'(2 | (s << 2)));
			w(2);
			`CHK("clk_oe", 2'(s), {pin_oe[6], pin_oe[4]})
			`CHK("p0_oe", 1'b0, pin_oe[0])
			`CHK("led", 2'b10, {led_drive_en, pin_oe[5]})
		end
		debug_active <= 1'b1;
		debug_data_oe <= 1'b1;
		w(3);
		`CHK("dbg_pin4", 2'b10, {pin_oe[4], pin_out[4]})
		`CHK("dbg_clk", 1'b1, debug_clock_pin)
		`CHK("dbg_dat", 1'b0, debug_data_pin)
		`CHK("led_dbg", 1'b0, led_drive_en)
		debug_active <= 1'b0;
		debug_data_oe <= 1'b0;
		wr(`GPOL_OFS_XTAL, 8'h01);
		w(2);
		`CHK("xtal_en", 1'b1, xtal_enable)
		`CHK("xtal_in", pin_in[0], crystal_osc_input)
		nvm_prog <= 1'b1;
		w(3);
		`CHK("xtal_vpp", 1'b0, xtal_enable)
		shutdown <= 1'b1;
		press[2] <= 1'b1;
		w(1);
		`CHK("wake_btn", 1'b1, wake_req)
		press[2] <= 1'b0;
		w(1);
		`CHK("no_wake", 1'b0, wake_req)
		press[0] <= 1'b1;
		w(1);
		`CHK("wake_p0", 1'b1, wake_req)
		summarize();
	end
endmodule

/* verilog/gpol_cfg.svh */
// Purpose: register offsets, field positions, reset values and pin indices
// Assumes: byte-wide registers on a word-aligned plain register port
// Notes: definitions only
`ifndef GPOL_CFG_SVH
`define GPOL_CFG_SVH
`define GPOL_AW        5
`define GPOL_OFS_CTRL  5'h00
`define GPOL_OFS_SET   5'h04
`define GPOL_OFS_OUT   5'h08
`define GPOL_OFS_DRV   5'h0C
`define GPOL_OFS_PIN   5'h10
`define GPOL_OFS_XTAL  5'h14
`define GPOL_B_STROBE  7
`define GPOL_B_MATRIX  6
`define GPOL_B_ROFF    5
`define GPOL_B_REFEN   0
`define GPOL_B_CLKEN   1
`define GPOL_B_CLKSEL0 2
`define GPOL_B_CLKSEL1 3
`define GPOL_B_XTALEN  0
`define GPOL_RST_OUT   8'hFF
`define GPOL_RST_DRV   8'h00
`define GPOL_PIN_XTAL  0
`define GPOL_PIN_REF   3
`define GPOL_PIN_DDAT  4
`define GPOL_PIN_LED   5
`define GPOL_PIN_CK6   6
`define GPOL_MX_LO     1
`define GPOL_MX_HI     3
`endif

/* verilog/gpol_pad_option.sv */
// Purpose: pad special-role muxing and retained matrix/pullup-off option latch
// Assumes: pad_rst is the pad power-on reset, rst the core reset
// Notes: pin outputs registered; shutdown overrides come straight from the pad latch
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
`include "gpol_cfg.svh"

// Summary of operation
// R01: pin 0 is input only, also crystal input and programming voltage.
// R02: pin 5 drives the LED only; LED drive is off during debug.
// R03: in debug, pin 5 carries debug clock and pin 4 debug data.
// R04: customer clock enabled separately on pin 4 and pin 6.
// R05: pin 3 can supply the frequency counter reference clock.
// R06: pullup-disconnect option held by pads, kept through shutdown.
// R07: matrix and pullup-disconnect held in a two-bit retained pad latch.
// R08: in shutdown, any pin pulled low requests wake.
// R09: matrix mode serves 3x2 or 3x6 button arrangements, scanned by firmware.
// R10: matrix set: pins 3..1 driven low during shutdown.
// R11: matrix latched: pins 3..1 lose pullups and get pulldowns.
// R12: software latches matrix 1 with pullup-disconnect 0.
// R13: software makes pins 3..1 inputs before enabling matrix.
// R14: software clears matrix after wake before scanning.
// R15: firmware scans pins 3..1 with patterns 110, 101, 011, 111.
// R16: options take effect only through a strobe 0-1-0 toggle.
// R17: control register reads return latched options, not pending ones.
// R18: matrix bit 6, pullup-disconnect bit 5, strobe bit 7.
// R19: highest-priority role on a pin wins; lower role controls ignored.
// R20: pad latch transparent while strobe high, holds once low.
module gpol_pad_option #(
	parameter int PINS = 8
) (
	// clock and resets
	input  wire  logic                core_clk,
	input  wire  logic                rst,
	input  wire  logic                pad_rst,
	// register port
	input  wire  gpol_pkg::gpol_addr_t reg_addr,
	input  wire  gpol_pkg::gpol_byte_t reg_wdata,
	input  wire  logic                reg_wr,
	input  wire  logic                reg_rd,
	output logic [7:0]                reg_rdata,
	// pads
	input  wire  logic [PINS-1:0]     pin_in,
	output logic [PINS-1:0]           pin_out,
	output logic [PINS-1:0]           pin_oe,
	output logic [PINS-1:0]           pin_pullup_en,
	output logic [PINS-1:0]           pin_pulldown_en,
	// system side
	input  wire  logic                shutdown,
	input  wire  logic                nvm_prog,
	input  wire  logic                debug_active,
	input  wire  logic                debug_data_out,
	input  wire  logic                debug_data_oe,
	input  wire  logic                cust_clk,
	output logic                      debug_data_pin,
	output logic                      debug_clock_pin,
	output logic                      freq_ref_clk,
	output logic                      crystal_osc_input,
	output logic                      xtal_enable,
	output logic                      led_drive_en,
	output logic                      wake_req,
	output logic                      opt_matrix,
	output logic                      opt_roff
);
	import gpol_pkg::*;

	logic [7:0]    pin_in_x;
	logic [7:0]    port0_output_latch_r;
	logic [7:0]    port0_drive_config_r;
	logic [7:0]    pin_out_r;
	logic [7:0]    pin_oe_r;
	logic [7:0]    gp_oe;
	logic [7:0]    pu_x;
	logic [7:0]    pd_x;
	logic [7:0]    oe_x;
	logic [7:0]    out_x;
	logic [7:0]    rdata_nxt;
	logic [7:0]    rdata_r;
	logic          strobe_r;
	logic          pend_matrix_r;
	logic          pend_roff_r;
	logic          opt_matrix_r;
	logic          opt_roff_r;
	logic          ref_en_r;
	logic          clk_en_r;
	logic [1:0]    clk_sel_r;
	logic          xtal_en_r;
	gpol_p4_role_t p4_role;

	// 10-pin part has six pads; only 8 (14-pin port 0) or 6 are served
	generate
		if (PINS == 8) begin : g_p8
			assign pin_in_x = pin_in;
		end else if (PINS == 6) begin : g_p6
			assign pin_in_x = {2'b11, pin_in};
		end else begin : g_bad
			$error("gpol_pad_option: PINS must be 6 or 8"); // R09
		end
	endgenerate

	wire wr_ctrl = reg_wr && (reg_addr == `GPOL_OFS_CTRL);

	// control register: pending options and the strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			strobe_r      <= 1'b0;
			pend_matrix_r <= 1'b0;
			pend_roff_r   <= 1'b0;
		end else if (wr_ctrl) begin
			strobe_r      <= reg_wdata[`GPOL_B_STROBE]; // R18
			pend_matrix_r <= reg_wdata[`GPOL_B_MATRIX]; // R18
			pend_roff_r   <= reg_wdata[`GPOL_B_ROFF]; // R18
		end
	end

	// pad latch: own power-on reset so a core reset on wake keeps the options
	always_ff @(posedge core_clk or posedge pad_rst) begin
		if (pad_rst) begin
			opt_matrix_r <= 1'b0;
			opt_roff_r   <= 1'b0;
		end else if (strobe_r && !shutdown) begin
			opt_matrix_r <= pend_matrix_r; // R07 R16 R20
			opt_roff_r   <= pend_roff_r; // R06 R07 R16 R20
		end
	end

	// special-role and port registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ref_en_r             <= 1'b0;
			clk_en_r             <= 1'b0;
			clk_sel_r            <= 2'b00;
			xtal_en_r            <= 1'b0;
			port0_output_latch_r <= `GPOL_RST_OUT;
			port0_drive_config_r <= `GPOL_RST_DRV;
		end else if (reg_wr) begin
			case (reg_addr)
				`GPOL_OFS_SET: begin
					ref_en_r  <= reg_wdata[`GPOL_B_REFEN];
					clk_en_r  <= reg_wdata[`GPOL_B_CLKEN];
					clk_sel_r <= reg_wdata[`GPOL_B_CLKSEL1:`GPOL_B_CLKSEL0];
				end
				`GPOL_OFS_OUT: port0_output_latch_r <= reg_wdata;
				`GPOL_OFS_DRV: port0_drive_config_r <= reg_wdata;
				`GPOL_OFS_XTAL: xtal_en_r <= reg_wdata[`GPOL_B_XTALEN];
				default: ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			`GPOL_OFS_CTRL: begin
				rdata_nxt[`GPOL_B_STROBE] = strobe_r;
				rdata_nxt[`GPOL_B_MATRIX] = opt_matrix_r; // R17
				rdata_nxt[`GPOL_B_ROFF]   = opt_roff_r; // R17
			end
			`GPOL_OFS_SET: begin
				rdata_nxt[`GPOL_B_REFEN]                    = ref_en_r;
				rdata_nxt[`GPOL_B_CLKEN]                    = clk_en_r;
				rdata_nxt[`GPOL_B_CLKSEL1:`GPOL_B_CLKSEL0] = clk_sel_r;
			end
			`GPOL_OFS_OUT: rdata_nxt = port0_output_latch_r;
			`GPOL_OFS_DRV: rdata_nxt = port0_drive_config_r;
			`GPOL_OFS_PIN: rdata_nxt = pin_in_x;
			`GPOL_OFS_XTAL: rdata_nxt[`GPOL_B_XTALEN] = xtal_en_r;
			default:       rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 8'h00;
		end
	end
	assign reg_rdata = rdata_r;

	// plain port bit: push-pull drives always, open-drain only pulls low
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_gp
			assign gp_oe[gi] = port0_drive_config_r[gi] || !port0_output_latch_r[gi];
			// retained pad controls, valid without core power
			if (gi >= `GPOL_MX_LO && gi <= `GPOL_MX_HI) begin : g_mx
				assign pu_x[gi] = !opt_matrix_r && !opt_roff_r; // R06 R11
				assign pd_x[gi] = opt_matrix_r; // R11
			end else begin : g_nm
				assign pu_x[gi] = 1'b1;
				assign pd_x[gi] = 1'b0;
			end
		end
	endgenerate

	// debug owns pin 4 over the clock output, which owns it over the port
	always_comb begin
		if (debug_active) begin
			p4_role = GPOL_P4_DBG; // R19
		end else if (clk_en_r && clk_sel_r[0]) begin
			p4_role = GPOL_P4_CLK; // R04 R19
		end else begin
			p4_role = GPOL_P4_GPIO;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_out_r <= 8'h00;
			pin_oe_r  <= 8'h00;
		end else begin
			pin_out_r <= port0_output_latch_r;
			pin_oe_r  <= gp_oe;
			pin_oe_r[`GPOL_PIN_XTAL] <= 1'b0; // R01
			if (ref_en_r) begin
				pin_oe_r[`GPOL_PIN_REF] <= 1'b0; // R05 R19
			end
			case (p4_role)
				GPOL_P4_DBG: begin
					pin_out_r[`GPOL_PIN_DDAT] <= debug_data_out; // R03
					pin_oe_r[`GPOL_PIN_DDAT]  <= debug_data_oe; // R03
				end
				GPOL_P4_CLK: begin
					pin_out_r[`GPOL_PIN_DDAT] <= cust_clk; // R04
					pin_oe_r[`GPOL_PIN_DDAT]  <= 1'b1;
				end
				default: ;
			endcase
			// led pin is never a driven output; the current sink is separate
			pin_out_r[`GPOL_PIN_LED] <= 1'b0;
			pin_oe_r[`GPOL_PIN_LED]  <= 1'b0; // R02
			if (clk_en_r && clk_sel_r[1]) begin
				pin_out_r[`GPOL_PIN_CK6] <= cust_clk; // R04 R19
				pin_oe_r[`GPOL_PIN_CK6]  <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			led_drive_en <= 1'b0;
			xtal_enable  <= 1'b0;
		end else begin
			led_drive_en <= port0_output_latch_r[`GPOL_PIN_LED] && !debug_active; // R02
			xtal_enable  <= xtal_en_r && !nvm_prog; // R01 R19
		end
	end

	// shutdown: core registers are meaningless, pad latch alone decides
	always_comb begin
		out_x = pin_out_r;
		oe_x  = pin_oe_r;
		if (shutdown) begin
			out_x = 8'h00;
			oe_x  = 8'h00;
			oe_x[`GPOL_MX_HI:`GPOL_MX_LO] = {3{opt_matrix_r}}; // R10
		end
	end

	assign pin_out         = out_x[PINS-1:0];
	assign pin_oe          = oe_x[PINS-1:0];
	assign pin_pullup_en   = pu_x[PINS-1:0];
	assign pin_pulldown_en = pd_x[PINS-1:0];
	assign wake_req        = shutdown && !(&pin_in_x); // R08
	assign freq_ref_clk    = ref_en_r && pin_in_x[`GPOL_PIN_REF]; // R05
	assign debug_data_pin  = pin_in_x[`GPOL_PIN_DDAT]; // R03
	assign debug_clock_pin = debug_active && pin_in_x[`GPOL_PIN_LED]; // R03
	assign crystal_osc_input = pin_in_x[`GPOL_PIN_XTAL]; // R01
	assign opt_matrix      = opt_matrix_r;
	assign opt_roff        = opt_roff_r;

	read_latched_a: assert property (@(posedge core_clk) disable iff (rst) // R17
		(reg_rd && reg_addr == `GPOL_OFS_CTRL) |=>
		reg_rdata[`GPOL_B_MATRIX:`GPOL_B_ROFF] == $past({opt_matrix_r, opt_roff_r}))
		else $error("control read does not show latched options");
	latch_hold_a: assert property (@(posedge core_clk) disable iff (rst || pad_rst) // R16
		(!strobe_r ##1 !strobe_r) |-> $stable({opt_matrix_r, opt_roff_r}))
		else $error("pad latch changed without strobe");
	latch_load_a: assert property (@(posedge core_clk) disable iff (rst || pad_rst) // R20
		(strobe_r && !shutdown) |=> {opt_matrix_r, opt_roff_r} == $past({pend_matrix_r,
		pend_roff_r}))
		else $error("pad latch not transparent while strobe high");
	xtal_input_a: assert property (@(posedge core_clk) disable iff (rst) // R01
		!pin_oe[`GPOL_PIN_XTAL])
		else $error("pin 0 driven");
	led_debug_a: assert property (@(posedge core_clk) disable iff (rst) // R02
		debug_active[*2] |-> !led_drive_en)
		else $error("led driven during debug");
	dbg_data_a: assert property (@(posedge core_clk) disable iff (rst) // R03
		(debug_active && !shutdown) ##1 !shutdown |-> pin_oe[`GPOL_PIN_DDAT] ==
		$past(debug_data_oe))
		else $error("debug data pin not following debug enable");
	clk6_out_a: assert property (@(posedge core_clk) disable iff (rst) // R04
		(clk_en_r && clk_sel_r[1]) ##1 !shutdown |-> pin_oe[`GPOL_PIN_CK6] &&
		pin_out[`GPOL_PIN_CK6] == $past(cust_clk))
		else $error("clock output missing on pin 6");
	ref_input_a: assert property (@(posedge core_clk) disable iff (rst) // R05
		ref_en_r ##1 !shutdown |-> !pin_oe[`GPOL_PIN_REF])
		else $error("reference pin driven");
	matrix_sleep_a: assert property (@(posedge core_clk) disable iff (rst) // R10
		(shutdown && opt_matrix_r) |-> pin_oe[`GPOL_MX_HI:`GPOL_MX_LO] == '1 &&
		pin_out[`GPOL_MX_HI:`GPOL_MX_LO] == '0)
		else $error("matrix pins not pulled low in shutdown");
	matrix_pads_a: assert property (@(posedge core_clk) disable iff (rst) // R11
		opt_matrix_r |-> pin_pulldown_en[`GPOL_MX_HI:`GPOL_MX_LO] == '1 &&
		pin_pullup_en[`GPOL_MX_HI:`GPOL_MX_LO] == '0)
		else $error("matrix pad pulls wrong");
	wake_req_a: assert property (@(posedge core_clk) disable iff (rst) // R08
		(shutdown && pin_in != '1) |-> wake_req)
		else $error("no wake on grounded pin");
endmodule

/* verilog/gpol_pkg.sv */
// Purpose: shared types of the pad option block
// Assumes: gpol_cfg.svh holds all numeric constants
// Notes: none
`include "gpol_cfg.svh"
package gpol_pkg;
	typedef logic [`GPOL_AW-1:0] gpol_addr_t;
	typedef logic [7:0]          gpol_byte_t;
	// role owning the shared debug-data pin, highest priority first
	typedef enum logic [2:0] {
		GPOL_P4_DBG  = 3'b001,
		GPOL_P4_CLK  = 3'b010,
		GPOL_P4_GPIO = 3'b100
	} gpol_p4_role_t;
endpackage
